// *** src/itv_pkg.sv ***
package itv_pkg;
  // ==========================================================
  // bus register map (byte addresses)
  localparam logic [7:0] ADDR_REQ = 8'h00;
  localparam logic [7:0] ADDR_REQ_HI = 8'h04;
  localparam logic [7:0] ADDR_EN = 8'h08;
  localparam logic [7:0] ADDR_EN_HI = 8'h0C;
  localparam logic [7:0] ADDR_TRAP_FLAG = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;
  localparam logic [7:0] ADDR_VECTOR = 8'h1C;
  localparam logic [7:0] ADDR_SWTRAP = 8'h20;
  localparam logic [7:0] ADDR_PEC_CTRL = 8'h24;
  localparam logic [7:0] ADDR_PRIO_BASE = 8'h40;
  localparam int NSRC = 38;
  localparam int NPEC = 8;
  // ==========================================================
  // trap numbers
  localparam logic [6:0] TRAP_RESET = 7'h00;
  localparam logic [6:0] TRAP_NMI = 7'h02;
  localparam logic [6:0] TRAP_STACK_OVER_FLAG = 7'h04;
  localparam logic [6:0] TRAP_STACK_UNDER_FLAG = 7'h06;
  localparam logic [6:0] TRAP_CLASS_B = 7'h0A;
  // trap flag register bit positions
  localparam int TF_NMI = 15;
  localparam int TF_STACK_OVER_FLAG = 14;
  localparam int TF_STACK_UNDER_FLAG = 13;
  localparam int TF_UNDEFINED_OPCODE_FLAG = 7;
  localparam int TF_PROTECTED_INSTR_FAULT_FLAG = 3;
  localparam int TF_ILLEGAL_WORD_OPERAND_FLAG = 2;
  localparam int TF_ILLEGAL_INSTR_ACCESS_FLAG = 1;
  localparam int TF_ILLEGAL_EXT_BUS_FLAG = 0;
  // status bits
  localparam int ST_TRAP = 0;
  localparam int ST_INT = 1;
  localparam int ST_PEC = 2;
  localparam int ST_PEC_DONE = 3;
  // class priority of traps: a=3, b=2
  localparam logic [1:0] TPRIO_NONE = 2'h0;
  localparam logic [1:0] TPRIO_B = 2'h2;
  localparam logic [1:0] TPRIO_A = 2'h3;

  typedef struct packed {
    logic take;
    logic [6:0] trap_num;
    logic [8:0] vector;
  } itv_entry_s;

  typedef enum logic [1:0] {ITV_IDLE, ITV_TRAP, ITV_INT, ITV_PEC} itv_state_e;

  // source index to trap number, in table order
  function automatic logic [6:0] itv_src_trap(input int i);
    logic [6:0] t;
    t = 7'h00;
    if (i < 10) t = 7'(7'h32 + i);
    else if (i == 10) t = 7'h3C;
    else if (i < 14) t = 7'(7'h44 + i - 11);
    else begin
      case (i)
        14: t = 7'h20; 15: t = 7'h21; 16: t = 7'h3D; 17: t = 7'h3E;
        18: t = 7'h22; 19: t = 7'h23; 20: t = 7'h24; 21: t = 7'h25;
        22: t = 7'h26; 23: t = 7'h27; 24: t = 7'h28; 25: t = 7'h29;
        26: t = 7'h2A; 27: t = 7'h47; 28: t = 7'h2B; 29: t = 7'h2C;
        30: t = 7'h2D; 31: t = 7'h2E; 32: t = 7'h2F; 33: t = 7'h3F;
        34: t = 7'h40; 35: t = 7'h41; 36: t = 7'h42; 37: t = 7'h43;
        default: t = 7'h00;
      endcase
    end
    return t;
  endfunction
endpackage

// *** src/itv_prio_arb.sv ***
`timescale 1ns/1ps
// ==========================================================
// picks the highest priority pending enabled source
module itv_prio_arb (
  input wire logic [itv_pkg::NSRC-1:0] req,
  input wire logic [itv_pkg::NSRC*4-1:0] prio,
  output logic found,
  output logic [5:0] idx,
  output logic [3:0] level
);
  always_comb begin
    found = 1'b0;
    idx = 6'h00;
    level = 4'h0;
    for (int i = 0; i < itv_pkg::NSRC; i++) begin
      if (req[i] && (!found || prio[i*4 +: 4] > level)) begin
        found = 1'b1;
        idx = 6'(i);
        level = prio[i*4 +: 4];
      end
    end
  end
endmodule

// *** src/itv_top.sv ***
`timescale 1ns/1ps
module itv_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic [itv_pkg::NSRC-1:0] src_event,
  input wire logic nmi_event,
  input wire logic stack_over_event,
  input wire logic stack_under_event,
  input wire logic [4:0] class_b_event,
  input wire logic service_done,
  output logic entry_valid,
  output logic [6:0] entry_trap_num,
  output logic [8:0] entry_vector,
  output logic pec_cycle,
  output logic [2:0] pec_channel,
  output logic [3:0] cpu_level,
  output logic irq
);
  // ==========================================================
  // declarations
  logic [itv_pkg::NSRC-1:0] req_r;
  logic [itv_pkg::NSRC-1:0] en_r;
  logic [itv_pkg::NSRC*4-1:0] prio_r;
  logic [15:0] trap_flag_register;
  logic [3:0] status_r;
  logic [3:0] mask_r;
  logic [1:0] trap_prio_r;
  logic [3:0] level_r;
  logic [7:0] pec_count_r [itv_pkg::NPEC];
  logic [itv_pkg::NPEC-1:0] pec_en_r;
  logic [itv_pkg::NPEC-1:0] pec_cont_r;
  logic [6:0] sw_trap_r;
  logic sw_trap_pend_r;
  itv_pkg::itv_state_e state_r;
  itv_pkg::itv_entry_s entry_nxt;
  logic [itv_pkg::NSRC-1:0] pend;
  logic arb_found;
  logic [5:0] arb_idx;
  logic [3:0] arb_level;
  logic [1:0] trap_cls;
  logic [6:0] trap_num;
  logic trap_take;
  logic int_take;
  logic pec_take;
  logic [2:0] pec_ch;
  logic wb_hit;
  logic wb_wr;
  logic wb_rd;
  logic [7:0] a;
  logic [4:0] prio_i;
  logic [15:0] trap_set;
  logic [3:0] st_set;

  assign a = wb_adr_i[7:0];
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_hit && wb_we_i;
  assign wb_rd = wb_hit && !wb_we_i;
  assign prio_i = 5'(a[7:2] - 6'h10);

  // ==========================================================
  // source request and enable flags
  assign pend = req_r & en_r;

  itv_prio_arb u_arb (
    .req(pend),
    .prio(prio_r),
    .found(arb_found),
    .idx(arb_idx),
    .level(arb_level)
  );

  // ==========================================================
  // hardware trap decode: class a beats class b
  always_comb begin
    trap_set = 16'h0000;
    trap_set[itv_pkg::TF_NMI] = nmi_event;
    trap_set[itv_pkg::TF_STACK_OVER_FLAG] = stack_over_event;
    trap_set[itv_pkg::TF_STACK_UNDER_FLAG] = stack_under_event;
    trap_set[itv_pkg::TF_UNDEFINED_OPCODE_FLAG] = class_b_event[4];
    trap_set[itv_pkg::TF_PROTECTED_INSTR_FAULT_FLAG] = class_b_event[3];
    trap_set[itv_pkg::TF_ILLEGAL_WORD_OPERAND_FLAG] = class_b_event[2];
    trap_set[itv_pkg::TF_ILLEGAL_INSTR_ACCESS_FLAG] = class_b_event[1];
    trap_set[itv_pkg::TF_ILLEGAL_EXT_BUS_FLAG] = class_b_event[0];
    trap_cls = itv_pkg::TPRIO_NONE;
    trap_num = itv_pkg::TRAP_RESET;
    if (nmi_event) begin
      trap_cls = itv_pkg::TPRIO_A;
      trap_num = itv_pkg::TRAP_NMI;
    end else if (stack_over_event) begin
      trap_cls = itv_pkg::TPRIO_A;
      trap_num = itv_pkg::TRAP_STACK_OVER_FLAG;
    end else if (stack_under_event) begin
      trap_cls = itv_pkg::TPRIO_A;
      trap_num = itv_pkg::TRAP_STACK_UNDER_FLAG;
    end else if (|class_b_event) begin
      trap_cls = itv_pkg::TPRIO_B;
      trap_num = itv_pkg::TRAP_CLASS_B;
    end
  end

  assign trap_take = (trap_cls != itv_pkg::TPRIO_NONE) &&
                     !(state_r == itv_pkg::ITV_TRAP && trap_prio_r >= trap_cls);
  assign int_take = !trap_take && state_r != itv_pkg::ITV_TRAP && arb_found &&
                    (state_r == itv_pkg::ITV_IDLE ? arb_level > 4'h0 : arb_level > level_r);
  // source index 0..7 route through transfer channels
  assign pec_ch = arb_idx[2:0];
  assign pec_take = int_take && arb_idx < 6'(itv_pkg::NPEC) && pec_en_r[pec_ch] &&
                    (pec_cont_r[pec_ch] || pec_count_r[pec_ch] != 8'h00);

  always_comb begin
    entry_nxt = '0;
    if (trap_take) begin
      entry_nxt.take = 1'b1;
      entry_nxt.trap_num = trap_num;
    end else if (int_take && !pec_take) begin
      entry_nxt.take = 1'b1;
      entry_nxt.trap_num = itv_pkg::itv_src_trap(int'(arb_idx));
    end else if (sw_trap_pend_r && state_r != itv_pkg::ITV_TRAP) begin
      entry_nxt.take = 1'b1;
      entry_nxt.trap_num = sw_trap_r;
    end
    entry_nxt.vector = {entry_nxt.trap_num, 2'b00};
  end

  // ==========================================================
  // service state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= itv_pkg::ITV_IDLE;
      trap_prio_r <= itv_pkg::TPRIO_NONE;
      level_r <= 4'h0;
    end else if (trap_take) begin
      state_r <= itv_pkg::ITV_TRAP;
      trap_prio_r <= trap_cls;
      level_r <= 4'hF;
    end else if (int_take && !pec_take) begin
      state_r <= itv_pkg::ITV_INT;
      level_r <= arb_level;
    end else if (service_done) begin
      state_r <= itv_pkg::ITV_IDLE;
      trap_prio_r <= itv_pkg::TPRIO_NONE;
      level_r <= 4'h0;
    end
  end

  // entry outputs; reset entry vectors to zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      entry_valid <= 1'b0;
      entry_trap_num <= itv_pkg::TRAP_RESET;
      entry_vector <= 9'h000;
      pec_cycle <= 1'b0;
      pec_channel <= 3'h0;
      cpu_level <= 4'h0;
    end else begin
      entry_valid <= entry_nxt.take;
      if (entry_nxt.take) begin
        entry_trap_num <= entry_nxt.trap_num;
        entry_vector <= entry_nxt.vector;
      end
      pec_cycle <= pec_take;
      pec_channel <= pec_ch;
      // mirrors the next service level so the level drops with service_done
      cpu_level <= trap_take ? 4'hF : (int_take && !pec_take) ? arb_level :
                   service_done ? 4'h0 : level_r;
    end
  end

  // ==========================================================
  // request flags: set wins over clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      req_r <= '0;
    end else begin
      for (int i = 0; i < itv_pkg::NSRC; i++) begin
        if (src_event[i]) begin
          req_r[i] <= 1'b1;
        end else if ((int_take && arb_idx == 6'(i)) ||
                     (wb_wr && a == itv_pkg::ADDR_REQ && i < 32 && wb_dat_i[i % 32]) ||
                     (wb_wr && a == itv_pkg::ADDR_REQ_HI && i >= 32 && wb_dat_i[i % 32])) begin
          req_r[i] <= 1'b0;
        end
      end
    end
  end

  // enables, priorities, transfer control
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      en_r <= '0;
      prio_r <= '0;
      mask_r <= 4'h0;
      pec_en_r <= '0;
      pec_cont_r <= '0;
    end else if (wb_wr) begin
      if (a == itv_pkg::ADDR_EN) en_r[31:0] <= wb_dat_i;
      if (a == itv_pkg::ADDR_EN_HI) en_r[itv_pkg::NSRC-1:32] <= wb_dat_i[itv_pkg::NSRC-33:0];
      if (a == itv_pkg::ADDR_MASK) mask_r <= wb_dat_i[3:0];
      if (a == itv_pkg::ADDR_PEC_CTRL) begin
        pec_en_r <= wb_dat_i[7:0];
        pec_cont_r <= wb_dat_i[15:8];
      end
      if (a >= itv_pkg::ADDR_PRIO_BASE &&
          a < 8'(itv_pkg::ADDR_PRIO_BASE + 8'(itv_pkg::NSRC * 2))) begin
        prio_r[prio_i*8 +: 8] <= wb_dat_i[7:0];
      end
    end
  end

  // transfer counters: one decrement per stolen cycle, none on channels with pec_cont_r set
  for (genvar c = 0; c < itv_pkg::NPEC; c++) begin : g_pec
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        pec_count_r[c] <= 8'h00;
      end else if (wb_wr && a == 8'(itv_pkg::ADDR_PEC_CTRL + 8'h04 + 8'(c * 4))) begin
        pec_count_r[c] <= wb_dat_i[7:0];
      end else if (pec_take && pec_ch == 3'(c) && !pec_cont_r[c]) begin
        pec_count_r[c] <= pec_count_r[c] - 8'h01;
      end
    end
  end

  // software trap request
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sw_trap_pend_r <= 1'b0;
      sw_trap_r <= 7'h00;
    end else if (wb_wr && a == itv_pkg::ADDR_SWTRAP) begin
      sw_trap_pend_r <= 1'b1;
      sw_trap_r <= wb_dat_i[6:0];
    end else if (!trap_take && !(int_take && !pec_take) && state_r != itv_pkg::ITV_TRAP) begin
      sw_trap_pend_r <= 1'b0;
    end
  end

  // ==========================================================
  // trap flags and status: set wins over clear
  assign st_set = {pec_take && !pec_cont_r[pec_ch] && pec_count_r[pec_ch] == 8'h01,
                   pec_take, int_take && !pec_take, trap_take};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      trap_flag_register <= 16'h0000;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (trap_set[i]) trap_flag_register[i] <= 1'b1;
        else if (wb_wr && a == itv_pkg::ADDR_TRAP_FLAG && !wb_dat_i[i])
          trap_flag_register[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_r <= 4'h0;
    end else begin
      status_r <= st_set | ((wb_rd && a == itv_pkg::ADDR_STATUS) ? 4'h0 : status_r);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((status_r | st_set) & mask_r & ~((wb_rd && a == itv_pkg::ADDR_STATUS) ?
             status_r : 4'h0));
    end
  end

  // ==========================================================
  // wishbone slave, ack one cycle after strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0000_0000;
      if (wb_rd) begin
        case (a)
          itv_pkg::ADDR_REQ: wb_dat_o <= req_r[31:0];
          itv_pkg::ADDR_REQ_HI: wb_dat_o <= 32'(req_r[itv_pkg::NSRC-1:32]);
          itv_pkg::ADDR_EN: wb_dat_o <= en_r[31:0];
          itv_pkg::ADDR_EN_HI: wb_dat_o <= 32'(en_r[itv_pkg::NSRC-1:32]);
          itv_pkg::ADDR_TRAP_FLAG: wb_dat_o <= {16'h0000, trap_flag_register};
          itv_pkg::ADDR_STATUS: wb_dat_o <= {28'h0000000, status_r};
          itv_pkg::ADDR_MASK: wb_dat_o <= {28'h0000000, mask_r};
          itv_pkg::ADDR_VECTOR: wb_dat_o <= {16'h0000, state_r, level_r, entry_trap_num,
                                             1'b0, 2'b00};
          itv_pkg::ADDR_PEC_CTRL: wb_dat_o <= {16'h0000, pec_cont_r, pec_en_r};
          default: begin
            // bounded by address so high offsets do not alias onto low pairs
            if (a >= itv_pkg::ADDR_PRIO_BASE &&
                a < 8'(itv_pkg::ADDR_PRIO_BASE + 8'(itv_pkg::NSRC * 2)))
              wb_dat_o <= {24'h000000, prio_r[prio_i*8 +: 8]};
          end
        endcase
      end
    end
  end
endmodule

// *** verif/interrupt_trap_vectoring_tb_top.sv ***
`timescale 1ns/1ps
// ==========================================================
// bench top
module interrupt_trap_vectoring_tb_top;
  logic clock, rstn, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, service_done;
  logic entry_valid, pec_cycle, irq;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rq;
  logic [3:0] wb_sel_i, cpu_level, lat;
  logic [itv_pkg::NSRC-1:0] src_event, m;
  logic [7:0] hw;
  logic [6:0] entry_trap_num;
  logic [8:0] entry_vector;
  logic [2:0] pec_channel;
  int fails, checks, i, k;
  logic [6:0] tn [8] = '{7'h02, 7'h04, 7'h06, 7'h0A, 7'h0A, 7'h0A, 7'h0A, 7'h0A};
  int fb [8] = '{itv_pkg::TF_NMI, itv_pkg::TF_STACK_OVER_FLAG, itv_pkg::TF_STACK_UNDER_FLAG, itv_pkg::TF_UNDEFINED_OPCODE_FLAG,
    itv_pkg::TF_PROTECTED_INSTR_FAULT_FLAG, itv_pkg::TF_ILLEGAL_WORD_OPERAND_FLAG, itv_pkg::TF_ILLEGAL_INSTR_ACCESS_FLAG, itv_pkg::TF_ILLEGAL_EXT_BUS_FLAG};
  int sx [6] = '{0, 10, 13, 27, 34, 37};
  logic [6:0] st [6] = '{7'h32, 7'h3C, 7'h46, 7'h47, 7'h40, 7'h43};

  always #5 clock = ~clock;

  itv_top dut (.clock, .rstn, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .src_event, .nmi_event(hw[7]), .stack_over_event(hw[6]),
    .stack_under_event(hw[5]), .class_b_event(hw[4:0]), .service_done, .entry_valid,
    .entry_trap_num, .entry_vector, .pec_cycle, .pec_channel, .cpu_level, .irq);
  itv_cpu_model cpu (.clock, .rstn, .entry_valid, .lat, .service_done);

  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clock);
    wb_adr_i <= {24'h000000, a};
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (wb_ack_o === 1'b1) break;
    end
    rq = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n == 20) begin
      fails++;
      close_out;
    end
  endtask

  task automatic fire(input logic [7:0] h, input logic [itv_pkg::NSRC-1:0] s);
    @(posedge clock);
    hw <= h;
    src_event <= s;
    @(posedge clock);
    hw <= 8'h00;
    src_event <= 38'h0;
  endtask

  // w says whether an entry with trap number t is due within the bound
  task automatic ent(input logic [6:0] t, input logic w);
    int n;
    logic g;
    // a trap enters on the edge that samples it, so look before waiting
    #1;
    g = entry_valid === 1'b1;
    for (n = 0; n < 12 && !g; n++) begin
      @(posedge clock);
      #1;
      g = entry_valid === 1'b1;
    end
    chk("entry", 32'(w), 32'(g));
    if (g) begin
      chk("trap number", 32'(t), 32'(entry_trap_num));
      chk("vector", 32'({t, 2'h0}), 32'(entry_vector));
    end
  endtask

  task automatic idle;
    int n;
    repeat (2) @(posedge clock);
    for (n = 0; n < 300 && cpu_level !== 4'h0; n++) @(posedge clock);
    if (n == 300) begin
      fails++;
      close_out;
    end
  endtask

  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    wb_adr_i = 32'h0;
    wb_dat_i = 32'h0;
    wb_we_i = 1'b0;
    wb_sel_i = 4'hF;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    src_event = 38'h0;
    hw = 8'h00;
    lat = 4'h2;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    #1;
    chk("reset trap number", 32'h0, 32'(entry_trap_num));
    chk("reset vector", 32'h0, 32'(entry_vector));
    for (i = 0; i < 8; i++) begin
      wb(itv_pkg::ADDR_TRAP_FLAG, 1'b1, 32'h0);
      fire(8'h80 >> i, 38'h0);
      ent(tn[i], 1'b1);
      idle;
      wb(itv_pkg::ADDR_TRAP_FLAG, 1'b0, 32'h0);
      chk("trap flag", 32'h1 << fb[i], rq);
      chk("masked irq", 32'h0, 32'(irq));
    end
    $display("test traps done");
    wb(itv_pkg::ADDR_STATUS, 1'b0, 32'h0);
    wb(itv_pkg::ADDR_MASK, 1'b1, 32'h2);
    for (i = 0; i < 6; i++) begin
      m = 38'h1 << sx[i];
      wb(8'(itv_pkg::ADDR_PRIO_BASE + 4 * (sx[i] / 2)), 1'b1, 32'h3 << (4 * (sx[i] % 2)));
      fire(8'h00, m);
      ent(st[i], 1'b0);
      wb(sx[i] < 32 ? itv_pkg::ADDR_REQ : itv_pkg::ADDR_REQ_HI, 1'b0, 32'h0);
      chk("request flag", 32'h1 << (sx[i] % 32), rq);
      wb(sx[i] < 32 ? itv_pkg::ADDR_EN : itv_pkg::ADDR_EN_HI, 1'b1,
        sx[i] < 32 ? m[31:0] : {26'h0, m[37:32]});
      ent(st[i], 1'b1);
      idle;
    end
    chk("irq raised", 32'h1, 32'(irq));
    wb(itv_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("status int", 32'h2, rq & 32'h2);
    repeat (2) @(posedge clock);
    chk("irq cleared", 32'h0, 32'(irq));
    $display("test sources done");
    @(posedge clock);
    lat <= 4'h0;
    wb(itv_pkg::ADDR_PRIO_BASE, 1'b1, 32'h55);
    wb(itv_pkg::ADDR_PRIO_BASE + 8'h04, 1'b1, 32'h09);
    wb(itv_pkg::ADDR_EN, 1'b1, 32'h7);
    fire(8'h00, 38'h1);
    ent(7'h32, 1'b1);
    chk("level", 32'h5, 32'(cpu_level));
    fire(8'h00, 38'h2);
    ent(7'h33, 1'b0);
    fire(8'h00, 38'h4);
    ent(7'h34, 1'b1);
    fire(8'h01, 38'h0);
    ent(7'h0A, 1'b1);
    fire(8'h80, 38'h0);
    ent(7'h02, 1'b1);
    chk("trap level", 32'hF, 32'(cpu_level));
    fire(8'h02, 38'h0);
    ent(7'h0A, 1'b0);
    fire(8'h00, 38'h1);
    ent(7'h32, 1'b0);
    lat <= 4'h2;
    idle;
    $display("test preemption done");
    wb(itv_pkg::ADDR_PEC_CTRL, 1'b1, 32'h1);
    wb(8'h28, 1'b1, 32'h1);
    wb(itv_pkg::ADDR_EN, 1'b1, 32'h1);
    fire(8'h00, 38'h1);
    for (k = 0; k < 12 && pec_cycle !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    chk("pec cycle", 32'h1, 32'(pec_cycle));
    chk("pec channel", 32'h0, 32'(pec_channel));
    wb(8'h28, 1'b0, 32'h0);
    chk("pec count", 32'h0, rq);
    fire(8'h00, 38'h1);
    ent(7'h32, 1'b1);
    idle;
    wb(itv_pkg::ADDR_SWTRAP, 1'b1, 32'h7F);
    ent(7'h7F, 1'b1);
    idle;
    wb(itv_pkg::ADDR_SWTRAP, 1'b1, 32'h10);
    ent(7'h10, 1'b1);
    idle;
    wb(8'hC0, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rq);
    $display("test misc done");
    close_out;
  end

  initial begin
    #900000;
    fails++;
    close_out;
  end
endmodule

// *** verif/itv_cpu_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// cpu core: ends each taken service after lat cycles, lat 0 holds it
module itv_cpu_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic entry_valid,
  input wire logic [3:0] lat,
  output logic service_done
);
  logic [3:0] cnt_r;
  logic [5:0] depth_r;
  logic fin;
  assign fin = depth_r != 6'h00 && lat != 4'h0 && cnt_r == lat;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 4'h0;
      depth_r <= 6'h00;
      service_done <= 1'b0;
    end else begin
      service_done <= fin;
      cnt_r <= (fin || depth_r == 6'h00) ? 4'h0 : cnt_r + 4'h1;
      depth_r <= depth_r + 6'(entry_valid) - 6'(fin);
    end
  end
endmodule

// *** verif/itv_top_properties.sv ***
`timescale 1ns/1ps
// ==========================================================
// port checker
module itv_top_props (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [itv_pkg::NSRC-1:0] src_event,
  input wire logic nmi_event,
  input wire logic stack_over_event,
  input wire logic stack_under_event,
  input wire logic [4:0] class_b_event,
  input wire logic service_done,
  input wire logic entry_valid,
  input wire logic [6:0] entry_trap_num,
  input wire logic [8:0] entry_vector,
  input wire logic pec_cycle,
  input wire logic [2:0] pec_channel,
  input wire logic [3:0] cpu_level,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic free;
  logic [6:0] a_num;
  assign free = cpu_level != 4'hF && !entry_valid;
  assign a_num = nmi_event ? 7'h02 : (stack_over_event ? 7'h04 : 7'h06);
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence entry_of(logic [6:0] t);
    entry_valid && entry_trap_num == t;
  endsequence
  ack_resp_a: assert property (bus_req |=> ack_once)
    else $error("bus answer not a single cycle after request");
  class_a_a: assert property ($onehot({nmi_event, stack_over_event, stack_under_event}) && free
    |=> entry_of($past(a_num))) else $error("class a trap not entered at once");
  class_b_a: assert property (|class_b_event && !nmi_event && !stack_over_event
    && !stack_under_event && free |=> entry_of(7'h0A)) else $error("class b trap not entered");
  vec_scale_a: assert property (entry_valid |-> entry_vector == {entry_trap_num, 2'h0})
    else $error("vector is not trap number times four");
  reserved_a: assert property (entry_valid |-> !(entry_trap_num inside {[7'h0B:7'h0F]}))
    else $error("reserved trap number selected");
  reset_vec_a: assert property ($rose(rstn) |-> entry_trap_num == 7'h00
    && entry_vector == 9'h000 && !entry_valid) else $error("entry outputs not zero after reset");
  trap_block_a: assert property (cpu_level == 4'hF && $past(cpu_level) == 4'hF |-> !pec_cycle)
    else $error("transfer cycle during trap service");
  trap_hold_a: assert property (cpu_level == 4'hF && !service_done
    |=> !(entry_valid && entry_trap_num >= 7'h10)) else $error("interrupt entered during trap");
endmodule

bind itv_top itv_top_props u_props (
  .clock, .rstn, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .src_event, .nmi_event, .stack_over_event, .stack_under_event,
  .class_b_event, .service_done, .entry_valid, .entry_trap_num, .entry_vector,
  .pec_cycle, .pec_channel, .cpu_level, .irq
);
